// ==== rtl/simd_alu_pkg.sv ====
/*
 * Shared types and constants of the packed lane datapath: operation,
 * lane width and second-operand mode encodings, lane geometry, masks
 * and reset values.
 * Assumes a single 250 MHz clock and a decode stage that presents a
 * whole instruction in one cycle.
 */
// What this block does
// - Fixed lane bit positions, halfword and byte
// - Scalar mode replicates lowest second-source lane
// - Immediate replicated, sign-extended unless op zero-extends
// - Lane add, truncated, no carry between lanes
// - Lane subtract, truncated, no borrow between lanes
// - Signed mean: truncated sum, arithmetic shift one
// - Unsigned mean: logical shift, zero-extended immediate
// - Per-lane minimum, signed or unsigned compare
// - Per-lane maximum, signed or unsigned compare
// - Logical right shift per lane, zero fill
// - Arithmetic right shift per lane, sign fill
// - Left shift per lane, top bits dropped
// - Halfword shifts use low four amount bits
// - Byte shifts use low three amount bits
// - Lane OR, XOR, AND in all modes
// - Lane absolute value of first source only
// - Extract chosen lane, sign or zero extend
// - Insert low lane, keep other destination bits
// - Dot product sums all lane products
// - Accumulating dot adds previous destination value
// - Unsigned dot treats all lanes unsigned
// - Signed dot treats all lanes signed
// - Mixed dot: first unsigned, second signed
package simd_alu_pkg;

	// Operations carried by the decode stage
	typedef enum logic [4:0] {
		lane_sum_op,
		lane_difference_op,
		lane_signed_mean_op,
		lane_unsigned_mean_op,
		lane_signed_minimum,
		lane_unsigned_minimum,
		lane_signed_maximum,
		lane_unsigned_maximum,
		lane_logical_right_shift,
		lane_arith_right_shift,
		lane_left_shift,
		lane_bitwise_or,
		lane_bitwise_xor,
		lane_bitwise_and,
		lane_magnitude,
		lane_extract_signed,
		lane_extract_unsigned,
		lane_insert,
		unsigned_dot_product,
		mixed_sign_dot_product,
		signed_dot_product,
		unsigned_dot_accumulate,
		mixed_sign_dot_accumulate,
		signed_dot_accumulate
	} alu_op_e;

	// Lane width of the instruction
	typedef enum logic {
		halfword_lanes,
		byte_lanes
	} lane_width_e;

	// Source of the second operand
	typedef enum logic [1:0] {
		vector_mode,
		scalar_replicate_mode,
		immediate_mode
	} operand_mode_e;

	localparam int WORD_BITS = 32; // Datapath width
	localparam int HALF_BITS = 16; // Halfword lane width
	localparam int BYTE_BITS = 8; // Byte lane width
	localparam int HALF_LANES = 2; // Lanes per word, halfword mode
	localparam int BYTE_LANES = 4; // Lanes per word, byte mode
	localparam int IMM_BITS = 6; // Immediate field width
	localparam int HALF_SHAMT_BITS = 4; // Shift amount bits, halfword
	localparam int BYTE_SHAMT_BITS = 3; // Shift amount bits, byte
	localparam logic [15:0] HALF_MASK = 16'hFFFF; // Halfword lane mask
	localparam logic [15:0] BYTE_MASK = 16'h00FF; // Byte lane mask
	localparam logic [31:0] RESULT_RESET = 32'h0000_0000; // Result after reset
	localparam logic VALID_RESET = 1'b0; // Valid after reset
	localparam int RESULT_LATENCY = 1; // Edges from issue to result

endpackage : simd_alu_pkg

// ==== rtl/lane_dot_unit.sv ====
/*
 * Lane dot-product unit: multiplies matching lanes with per-operand
 * signedness, sums the products and optionally adds an accumulator.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/100ps
module lane_dot_unit (
	input wire logic [31:0] a_in,
	input wire logic [31:0] b_in,
	input wire simd_alu_pkg::lane_width_e width_in,
	input wire logic a_signed_in,
	input wire logic b_signed_in,
	input wire logic [31:0] acc_in,
	input wire logic acc_en_in,
	output logic [31:0] sum_out
);
	import simd_alu_pkg::*;

	// Pick lane i and widen it to 17 bits with the requested sign
	function automatic logic signed [16:0] lane_ext(input logic [31:0] v,
			input lane_width_e w, input int i, input logic sgn);
		logic [15:0] l;
		l = 16'h0000;
		if (w == byte_lanes) begin
			l = {8'h00, v[i*BYTE_BITS +: BYTE_BITS]};
			return {{9{sgn & l[7]}}, l[7:0]};
		end
		if (i < HALF_LANES) begin
			l = v[i*HALF_BITS +: HALF_BITS];
		end
		return {sgn & l[15], l};
	endfunction : lane_ext

	// Sum of lane products; unused halfword lanes contribute zero
	always_comb begin
		logic signed [33:0] prod;
		logic [31:0] total;
		prod = '0;
		total = acc_en_in ? acc_in : RESULT_RESET;
		for (int i = 0; i < BYTE_LANES; i++) begin
			// Signedness chosen per operand covers all three variants
			prod = lane_ext(a_in, width_in, i, a_signed_in) * lane_ext(b_in, width_in, i, b_signed_in);
			total = total + prod[31:0];
		end
		sum_out = total;
	end

endmodule : lane_dot_unit

// ==== rtl/packed_simd_alu.sv ====
/*
 * Packed lane ALU: lane arithmetic, compare, shift, logic, magnitude,
 * extract/insert and dot products on two halfword or four byte lanes.
 * Assumes the decode stage presents operands, the old destination and
 * the immediate in the issue cycle; the result is registered once.
 */
`timescale 1ns/100ps
module packed_simd_alu (
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic issue_valid_in,
	input wire simd_alu_pkg::alu_op_e op_in,
	input wire simd_alu_pkg::lane_width_e width_in,
	input wire simd_alu_pkg::operand_mode_e mode_in,
	input wire logic [31:0] src1_in,
	input wire logic [31:0] src2_in,
	input wire logic [31:0] dest_old_in,
	input wire logic [5:0] six_bit_immediate_in,
	output logic result_valid_out,
	output logic [31:0] result_out
);
	import simd_alu_pkg::*;

	// Immediate extension chosen by operation
	logic imm_zero_ext;
	// Immediate widened to one lane
	logic [15:0] imm_lane;
	// Operand two after replication
	logic [31:0] second_operand;
	// Element-wise results for each lane width
	logic [31:0] half_result;
	logic [31:0] byte_result;
	// Extract and insert results
	logic [31:0] extract_result;
	logic [31:0] insert_result;
	// Dot unit controls and answer
	logic dot_a_signed;
	logic dot_b_signed;
	logic dot_acc_en;
	logic [31:0] dot_result;
	// Result selected for the output register
	logic [31:0] result_nxt;
	// Registered outputs
	logic [31:0] result_r;
	logic result_valid_r;

	/*
	 * One lane of the element-wise datapath. Byte lanes arrive in the
	 * low eight bits; the mask keeps the answer at lane width so no
	 * carry, borrow or shifted bit leaks into a neighbour.
	 */
	function automatic logic [15:0] lane_alu(input alu_op_e op,
			input lane_width_e w, input logic [15:0] a, input logic [15:0] b);
		logic [15:0] msk;
		logic [16:0] za;
		logic [16:0] zb;
		logic [16:0] sa;
		logic [16:0] sb;
		logic [15:0] sum;
		logic [3:0] amt;
		logic signed [16:0] sra_v;
		logic s_lt;
		logic u_lt;
		logic [15:0] res;
		// Lane width decides the mask and the sign position
		msk = (w == byte_lanes) ? BYTE_MASK : HALF_MASK;
		za = {1'b0, a & msk};
		zb = {1'b0, b & msk};
		sa = (w == byte_lanes) ? {{9{a[7]}}, a[7:0]} : {a[15], a};
		sb = (w == byte_lanes) ? {{9{b[7]}}, b[7:0]} : {b[15], b};
		// Truncated sum shared by add and both means
		sum = (a + b) & msk;
		// Upper amount bits are ignored, not checked
		if (w == byte_lanes) begin
			amt = {1'b0, b[BYTE_SHAMT_BITS-1:0]};
		end else begin
			amt = b[HALF_SHAMT_BITS-1:0];
		end
		sra_v = $signed(sa) >>> amt;
		s_lt = $signed(sa) < $signed(sb);
		u_lt = za < zb;
		case (op)
			// Plain wraparound arithmetic
			lane_sum_op: begin
				res = sum;
			end
			lane_difference_op: begin
				res = a - b;
			end
			// Mean: signed replicates the sign bit of the truncated sum, unsigned fills zero
			lane_signed_mean_op: begin
				if (w == byte_lanes) begin
					res = {8'h00, sum[7], sum[7:1]};
				end else begin
					res = {sum[15], sum[15:1]};
				end
			end
			lane_unsigned_mean_op: begin
				res = sum >> 1;
			end
			// Compares; equal lanes give the same value either way
			lane_signed_minimum: begin
				res = s_lt ? a : b;
			end
			lane_unsigned_minimum: begin
				res = u_lt ? a : b;
			end
			lane_signed_maximum: begin
				res = s_lt ? b : a;
			end
			lane_unsigned_maximum: begin
				res = u_lt ? b : a;
			end
			// Shifts by the per-lane amount
			lane_logical_right_shift: begin
				res = za[15:0] >> amt;
			end
			lane_arith_right_shift: begin
				res = sra_v[15:0];
			end
			lane_left_shift: begin
				res = a << amt;
			end
			// Bitwise logic
			lane_bitwise_or: begin
				res = a | b;
			end
			lane_bitwise_xor: begin
				res = a ^ b;
			end
			lane_bitwise_and: begin
				res = a & b;
			end
			// Most negative value maps to itself, as in two's complement
			lane_magnitude: begin
				res = sa[16] ? -a : a;
			end
			// Other operations do not use this path
			default: begin
				res = 16'h0000;
			end
		endcase
		return res & msk;
	endfunction : lane_alu

	/*
	 * Immediate extension. Unsigned means, unsigned compares and all
	 * shifts take the immediate zero-extended; everything else signed.
	 */
	always_comb begin
		case (op_in)
			lane_unsigned_mean_op: begin
				imm_zero_ext = 1'b1;
			end
			lane_unsigned_minimum, lane_unsigned_maximum: begin
				imm_zero_ext = 1'b1;
			end
			lane_logical_right_shift, lane_arith_right_shift, lane_left_shift: begin
				imm_zero_ext = 1'b1;
			end
			default: begin
				imm_zero_ext = 1'b0;
			end
		endcase
	end

	// Immediate widened to a lane; byte lanes use the low eight bits
	always_comb begin
		if (imm_zero_ext) begin
			imm_lane = {10'h000, six_bit_immediate_in};
		end else begin
			imm_lane = {{10{six_bit_immediate_in[IMM_BITS-1]}}, six_bit_immediate_in};
		end
	end

	/*
	 * Second operand. Scalar mode takes the lowest lane of the second
	 * register; immediate mode repeats the widened immediate.
	 */
	always_comb begin
		case (mode_in)
			vector_mode: begin
				second_operand = src2_in;
			end
			scalar_replicate_mode: begin
				if (width_in == byte_lanes) begin
					second_operand = {4{src2_in[7:0]}};
				end else begin
					second_operand = {2{src2_in[15:0]}};
				end
			end
			immediate_mode: begin
				if (width_in == byte_lanes) begin
					second_operand = {4{imm_lane[7:0]}};
				end else begin
					second_operand = {2{imm_lane}};
				end
			end
			// Unused code: fall back to vector behaviour
			default: begin
				second_operand = src2_in;
			end
		endcase
	end

	// Halfword lanes: 15:0 and 31:16, each computed on its own
	always_comb begin
		half_result = RESULT_RESET;
		for (int i = 0; i < HALF_LANES; i++) begin
			half_result[i*HALF_BITS +: HALF_BITS] = lane_alu(op_in, halfword_lanes,
				src1_in[i*HALF_BITS +: HALF_BITS], second_operand[i*HALF_BITS +: HALF_BITS]);
		end
	end

	// Byte lanes: 7:0, 15:8, 23:16, 31:24
	always_comb begin
		logic [15:0] lane_v;
		lane_v = 16'h0000;
		byte_result = RESULT_RESET;
		for (int i = 0; i < BYTE_LANES; i++) begin
			lane_v = lane_alu(op_in, byte_lanes, {8'h00, src1_in[i*BYTE_BITS +: BYTE_BITS]},
				{8'h00, second_operand[i*BYTE_BITS +: BYTE_BITS]});
			byte_result[i*BYTE_BITS +: BYTE_BITS] = lane_v[7:0];
		end
	end

	/*
	 * Extract: immediate bit 0 picks the halfword, bits 1:0 the byte.
	 * Higher immediate bits are ignored.
	 */
	always_comb begin
		logic [15:0] half_pick;
		logic [7:0] byte_pick;
		logic sgn;
		half_pick = src1_in[{six_bit_immediate_in[0], 4'h0} +: HALF_BITS];
		byte_pick = src1_in[{six_bit_immediate_in[1:0], 3'h0} +: BYTE_BITS];
		sgn = (op_in == lane_extract_signed);
		if (width_in == byte_lanes) begin
			extract_result = {{24{sgn & byte_pick[7]}}, byte_pick};
		end else begin
			extract_result = {{16{sgn & half_pick[15]}}, half_pick};
		end
	end

	/*
	 * Insert: the old destination is an operand, since the lanes not
	 * chosen must come back unchanged through the single write port.
	 */
	always_comb begin
		insert_result = dest_old_in;
		if (width_in == byte_lanes) begin
			insert_result[{six_bit_immediate_in[1:0], 3'h0} +: BYTE_BITS] = src1_in[7:0];
		end else begin
			insert_result[{six_bit_immediate_in[0], 4'h0} +: HALF_BITS] = src1_in[15:0];
		end
	end

	// Dot product signedness and accumulation per variant
	always_comb begin
		dot_a_signed = 1'b0;
		dot_b_signed = 1'b0;
		dot_acc_en = 1'b0;
		case (op_in)
			unsigned_dot_product: begin
				dot_a_signed = 1'b0;
			end
			mixed_sign_dot_product: begin
				dot_b_signed = 1'b1;
			end
			signed_dot_product: begin
				dot_a_signed = 1'b1;
				dot_b_signed = 1'b1;
			end
			unsigned_dot_accumulate: begin
				dot_acc_en = 1'b1;
			end
			mixed_sign_dot_accumulate: begin
				dot_b_signed = 1'b1;
				dot_acc_en = 1'b1;
			end
			signed_dot_accumulate: begin
				dot_a_signed = 1'b1;
				dot_b_signed = 1'b1;
				dot_acc_en = 1'b1;
			end
			// Not a dot operation; the unit output is unused
			default: begin
				dot_acc_en = 1'b0;
			end
		endcase
	end

	// Shared multiplier tree; the accumulator is the old destination
	lane_dot_unit dot_unit (
		.a_in(src1_in),
		.b_in(second_operand),
		.width_in(width_in),
		.a_signed_in(dot_a_signed),
		.b_signed_in(dot_b_signed),
		.acc_in(dest_old_in),
		.acc_en_in(dot_acc_en),
		.sum_out(dot_result)
	);

	/*
	 * Final selection. Products are wide, so this path is the long
	 * one; a second stage could be added if 4 ns is not met.
	 */
	always_comb begin
		case (op_in)
			lane_extract_signed, lane_extract_unsigned: begin
				result_nxt = extract_result;
			end
			lane_insert: begin
				result_nxt = insert_result;
			end
			unsigned_dot_product, mixed_sign_dot_product, signed_dot_product: begin
				result_nxt = dot_result;
			end
			unsigned_dot_accumulate, mixed_sign_dot_accumulate, signed_dot_accumulate: begin
				result_nxt = dot_result;
			end
			// Element-wise operations, both widths computed in parallel
			default: begin
				result_nxt = (width_in == byte_lanes) ? byte_result : half_result;
			end
		endcase
	end

	// Result word; held between issues, no status flags exist
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			result_r <= RESULT_RESET;
		end else if (issue_valid_in) begin
			result_r <= result_nxt;
		end
	end

	// Valid pulse one edge after each issue
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			result_valid_r <= VALID_RESET;
		end else begin
			result_valid_r <= issue_valid_in;
		end
	end

	// Outputs straight from the registers
	assign result_out = result_r;
	assign result_valid_out = result_valid_r;

endmodule : packed_simd_alu

// ==== dv/dest_reg_model.sv ====
/*
 * Destination register model standing for the register file write and read ports.
 * Assumes results arrive as a one-cycle registered pulse.
 */
`timescale 1ns/100ps
module dest_reg_model (
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic wr_in,
	input wire logic [31:0] word_in,
	output logic [31:0] dest_out
);
	logic [31:0] held_r; // Last written word
	// Capture every written result
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			held_r <= 32'h0000_0000;
		end else if (wr_in) begin
			held_r <= word_in;
		end
	end
	// Bypass, else a back-to-back issue would read a stale word
	assign dest_out = wr_in ? word_in : held_r;
endmodule : dest_reg_model

// ==== dv/packed_simd_alu_checker.sv ====
/*
 * Port-level assertions of the packed lane ALU.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/100ps
module packed_simd_alu_checker (
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic issue_valid_in,
	input wire simd_alu_pkg::alu_op_e op_in,
	input wire simd_alu_pkg::lane_width_e width_in,
	input wire simd_alu_pkg::operand_mode_e mode_in,
	input wire logic [31:0] src1_in,
	input wire logic [31:0] src2_in,
	input wire logic [5:0] six_bit_immediate_in,
	input wire logic result_valid_out,
	input wire logic [31:0] result_out
);
	import simd_alu_pkg::*;
	logic [31:0] s1_r; // Operands one cycle back
	logic [31:0] s2_r;
	logic [5:0] imm_r;
	logic hv; // Halfword vector issue
	logic bv; // Byte vector issue
	default clocking @(posedge clock_in); endclocking
	default disable iff (reset_in);
	// Delay operands to the answer cycle
	always_ff @(posedge clock_in) begin
		s1_r <= src1_in;
		s2_r <= src2_in;
		imm_r <= six_bit_immediate_in;
	end
	assign hv = issue_valid_in && width_in == halfword_lanes && mode_in == vector_mode;
	assign bv = issue_valid_in && width_in == byte_lanes && mode_in == vector_mode;
	property p_answer;
		issue_valid_in |=> result_valid_out;
	endproperty
	a_answer: assert property (p_answer) else $error("no result pulse after issue");
	property p_quiet;
		!issue_valid_in |=> !result_valid_out && $stable(result_out);
	endproperty
	a_quiet: assert property (p_quiet) else $error("result moved without issue");
	property p_reset;
		disable iff (1'b0) reset_in |=> !result_valid_out && result_out == RESULT_RESET;
	endproperty
	a_reset: assert property (p_reset) else $error("result not cleared by reset");
	property p_sum;
		hv && op_in == lane_sum_op |=> result_out == {s1_r[31:16] + s2_r[31:16], s1_r[15:0] + s2_r[15:0]};
	endproperty
	a_sum: assert property (p_sum) else $error("halfword sum wrong");
	property p_diff;
		bv && op_in == lane_difference_op |=> result_out == {s1_r[31:24] - s2_r[31:24],
			s1_r[23:16] - s2_r[23:16], s1_r[15:8] - s2_r[15:8], s1_r[7:0] - s2_r[7:0]};
	endproperty
	a_diff: assert property (p_diff) else $error("byte difference wrong");
	property p_scalar;
		issue_valid_in && op_in == lane_sum_op && width_in == halfword_lanes && mode_in == scalar_replicate_mode
			|=> result_out == {s1_r[31:16] + s2_r[15:0], s1_r[15:0] + s2_r[15:0]};
	endproperty
	a_scalar: assert property (p_scalar) else $error("scalar replicate wrong");
	property p_xor;
		(hv || bv) && op_in == lane_bitwise_xor |=> result_out == (s1_r ^ s2_r);
	endproperty
	a_xor: assert property (p_xor) else $error("lane xor wrong");
	property p_extract;
		issue_valid_in && op_in == lane_extract_unsigned && width_in == halfword_lanes
			|=> result_out == {16'h0000, imm_r[0] ? s1_r[31:16] : s1_r[15:0]};
	endproperty
	a_extract: assert property (p_extract) else $error("halfword extract wrong");
	property p_dot;
		hv && op_in == unsigned_dot_product |=> result_out == s1_r[15:0] * s2_r[15:0] + s1_r[31:16] * s2_r[31:16];
	endproperty
	a_dot: assert property (p_dot) else $error("unsigned dot wrong");
	// Main scenarios seen
	c_b2b: cover property (issue_valid_in [*2]);
	c_acc: cover property (issue_valid_in && op_in == signed_dot_accumulate);
	c_imm: cover property (issue_valid_in && mode_in == immediate_mode);
endmodule : packed_simd_alu_checker
bind packed_simd_alu packed_simd_alu_checker i_chk (.clock_in(clock_in), .reset_in(reset_in),
	.issue_valid_in(issue_valid_in), .op_in(op_in), .width_in(width_in), .mode_in(mode_in),
	.src1_in(src1_in), .src2_in(src2_in), .six_bit_immediate_in(six_bit_immediate_in),
	.result_valid_out(result_valid_out), .result_out(result_out));

// ==== dv/tb_packed_simd_alu.sv ====
/*
 * Self-checking bench of the packed lane ALU, one task per scenario.
 * Assumes the destination model feeds the old destination word.
 */
`timescale 1ns/100ps
module tb_packed_simd_alu;
	import simd_alu_pkg::*;
	logic clock_in = 0, reset_in = 1, iv = 0, rv;
	alu_op_e op = lane_sum_op;
	lane_width_e w = halfword_lanes;
	operand_mode_e m = vector_mode;
	logic [31:0] s1 = 0, s2 = 0, res, dold;
	logic [5:0] imm = 0;
	int n_errors = 0, checked = 0;
	localparam lane_width_e H = halfword_lanes;
	localparam lane_width_e B = byte_lanes;
	localparam operand_mode_e V = vector_mode;
	localparam operand_mode_e S = scalar_replicate_mode;
	localparam operand_mode_e I = immediate_mode;
	packed_simd_alu i_dut (.clock_in(clock_in), .reset_in(reset_in), .issue_valid_in(iv), .op_in(op),
		.width_in(w), .mode_in(m), .src1_in(s1), .src2_in(s2), .dest_old_in(dold),
		.six_bit_immediate_in(imm), .result_valid_out(rv), .result_out(res));
	dest_reg_model i_regs (.clock_in(clock_in), .reset_in(reset_in), .wr_in(rv), .word_in(res), .dest_out(dold));
	always #2 clock_in = ~clock_in;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Issue on a falling edge, judge just after the taking edge
	task go(input alu_op_e o, lane_width_e wd, operand_mode_e md, logic [31:0] a, b, logic [5:0] i, logic [31:0] e);
		@(negedge clock_in);
		// Enum inputs are assigned one by one, never through a packed concatenation
		iv = 1'b1;
		op = o;
		w = wd;
		m = md;
		s1 = a;
		s2 = b;
		imm = i;
		@(posedge clock_in);
		#1;
		chk({31'h0, rv}, 32'h1);
		chk(res, e);
	endtask : go
	task t_arith;
		go(lane_sum_op, H, V, 32'h0001_FFFF, 32'h0001_0001, 0, 32'h0002_0000);
		go(lane_difference_op, B, V, 32'h0000_0100, 32'h0101_0101, 0, 32'hFFFF_00FF);
		go(lane_sum_op, H, S, 32'h0001_0002, 32'hDEAD_0003, 0, 32'h0004_0005);
		go(lane_difference_op, B, S, 32'h1020_3040, 32'hFFFF_FF01, 0, 32'h0F1F_2F3F);
		go(lane_sum_op, H, I, 32'h0010_0020, 0, 6'h2A, 32'hFFFA_000A);
	endtask : t_arith
	task t_mean;
		go(lane_signed_mean_op, H, V, 32'h8000_0002, 32'h8000_7FFE, 0, 32'h0000_C000);
		go(lane_unsigned_mean_op, H, V, 32'h8000_0002, 32'h8000_7FFE, 0, 32'h0000_4000);
		go(lane_unsigned_mean_op, B, I, 32'h0101_0101, 0, 6'h3F, 32'h2020_2020);
		go(lane_signed_mean_op, B, I, 32'h0303_0303, 0, 6'h3F, 32'h0101_0101);
	endtask : t_mean
	task t_minmax;
		go(lane_signed_minimum, H, V, 32'h8000_0001, 32'h0001_8000, 0, 32'h8000_8000);
		go(lane_unsigned_minimum, H, V, 32'h8000_0001, 32'h0001_8000, 0, 32'h0001_0001);
		go(lane_signed_maximum, H, V, 32'h8000_0001, 32'h0001_8000, 0, 32'h0001_0001);
		go(lane_unsigned_maximum, H, V, 32'h8000_0001, 32'h0001_8000, 0, 32'h8000_8000);
		go(lane_unsigned_minimum, H, I, 32'h0100_0010, 0, 6'h3F, 32'h003F_0010);
		go(lane_signed_maximum, B, I, 32'h8005_FE00, 0, 6'h3F, 32'hFF05_FF00);
		go(lane_unsigned_maximum, B, I, 32'h0050_0010, 0, 6'h3F, 32'h3F50_3F3F);
	endtask : t_minmax
	// Upper amount bits kept at zero by this stimulus
	task t_shift;
		go(lane_logical_right_shift, H, V, 32'h8000_8000, 32'h000F_0001, 0, 32'h0001_4000);
		go(lane_arith_right_shift, H, V, 32'h8000_8000, 32'h000F_0001, 0, 32'hFFFF_C000);
		go(lane_left_shift, H, V, 32'h8001_0001, 32'h0001_000F, 0, 32'h0002_8000);
		go(lane_left_shift, B, I, 32'h0101_0101, 0, 6'h07, 32'h8080_8080);
		go(lane_arith_right_shift, B, S, 32'h8080_0101, 32'h0000_0007, 0, 32'hFFFF_0000);
		go(lane_logical_right_shift, B, I, 32'h8080_0101, 0, 6'h00, 32'h8080_0101);
	endtask : t_shift
	task t_logic;
		go(lane_bitwise_or, B, V, 32'hF0F0_F0F0, 32'hFF00_FF00, 0, 32'hFFF0_FFF0);
		go(lane_bitwise_xor, B, V, 32'hF0F0_F0F0, 32'hFF00_FF00, 0, 32'h0FF0_0FF0);
		go(lane_bitwise_and, H, I, 32'h1234_5678, 0, 6'h20, 32'h1220_5660);
		go(lane_bitwise_or, H, S, 32'h1230_4560, 32'h0000_000F, 0, 32'h123F_456F);
		go(lane_magnitude, B, V, 32'h80FF_7F01, 32'hFFFF_FFFF, 0, 32'h8001_7F01);
		go(lane_magnitude, H, V, 32'hFFFE_0005, 32'hFFFF_FFFF, 0, 32'h0002_0005);
	endtask : t_logic
	task t_lane;
		go(lane_extract_signed, B, V, 32'h1280_3456, 0, 6'h02, 32'hFFFF_FF80);
		go(lane_extract_unsigned, B, V, 32'h1280_3456, 0, 6'h02, 32'h0000_0080);
		go(lane_extract_signed, H, V, 32'h9000_0001, 0, 6'h01, 32'hFFFF_9000);
		go(lane_insert, B, V, 32'h0000_00AB, 0, 6'h01, 32'hFFFF_AB00);
		go(lane_insert, H, V, 32'h0000_1234, 0, 6'h00, 32'hFFFF_1234);
	endtask : t_lane
	task t_dot;
		go(lane_sum_op, H, V, 0, 32'h0000_000A, 0, 32'h0000_000A);
		go(signed_dot_accumulate, B, V, 32'hFF02_0304, 32'h0101_0101, 0, 32'h0000_0012);
		go(unsigned_dot_accumulate, B, V, 32'h0101_0101, 32'h0202_0202, 0, 32'h0000_001A);
		go(mixed_sign_dot_accumulate, B, V, 32'h0000_00FF, 32'h0000_00FF, 0, 32'hFFFF_FF1B);
		go(unsigned_dot_product, H, V, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 0, 32'hFFFC_0002);
		go(mixed_sign_dot_product, H, V, 32'hFFFF_0002, 32'hFFFF_0003, 0, 32'hFFFF_0007);
		go(signed_dot_product, H, V, 32'hFFFF_0002, 32'hFFFF_0003, 0, 32'h0000_0007);
		go(signed_dot_product, B, I, 32'h0102_0304, 0, 6'h3F, 32'hFFFF_FFF6);
	endtask : t_dot
	// Idle holds the word, then a reset in mid-run clears it
	task t_hold;
		@(negedge clock_in);
		iv = 0;
		@(posedge clock_in);
		#1;
		chk({31'h0, rv}, 32'h0);
		chk(res, 32'hFFFF_FFF6);
		@(negedge clock_in);
		reset_in = 1;
		@(posedge clock_in);
		#1;
		chk({31'h0, rv}, 32'h0);
		chk(res, RESULT_RESET);
		@(negedge clock_in);
		reset_in = 0;
		// Issues right after the mid-run reset; halfword unsigned extract, both lanes
		go(lane_extract_unsigned, H, V, 32'hABCD_1234, 0, 6'h01, 32'h0000_ABCD);
		go(lane_extract_unsigned, H, V, 32'hABCD_1234, 0, 6'h00, 32'h0000_1234);
	endtask : t_hold
	task end_of_test;
		$display("errors=%0d checks=%0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_of_test
	// Main sequence
	initial begin
		repeat (3) @(posedge clock_in);
		@(negedge clock_in);
		reset_in = 0;
		chk({31'h0, rv}, 32'h0);
		chk(res, RESULT_RESET);
		t_arith;
		t_mean;
		t_minmax;
		t_shift;
		t_logic;
		t_lane;
		t_dot;
		t_hold;
		end_of_test;
	end
	// Watchdog, far beyond the fifty or so cycles needed
	initial begin
		#40000;
		n_errors++;
		end_of_test;
	end
endmodule : tb_packed_simd_alu
